/* File: core/flash_addr_defs.vh */
// Purpose: Constants for flash block address decoding
// Assumes: 18-bit byte address from user fabric logic
// Notes: Field positions and organisation counts
`ifndef FLASH_ADDR_DEFS_VH
`define FLASH_ADDR_DEFS_VH

`define ADDR_W 18
`define SECTOR_HI 17
`define SECTOR_LO 12
`define PAGE_HI 11
`define PAGE_LO 7
`define BLOCK_HI 6
`define BLOCK_LO 4
`define BYTE_HI 3
`define BYTE_LO 0
`define AUX_BYTE_HI 1
`define AUX_BYTE_LO 0
`define SECTOR_W 6
`define PAGE_W 5
`define BLOCK_W 3
`define BYTE_W 4
`define NUM_SECTORS 64
`define PAGES_PER_SECTOR 32
`define BLOCKS_PER_PAGE 8
`define DATA_BLOCK_BYTES 16
`define AUX_BLOCK_BYTES 4
`define PROTECTED_SECTOR 6'h00
`define ZERO_PAGE 5'h00
`define ZERO_BLOCK 3'h0
`define ZERO_BYTE 4'h0
`define ZERO_AUX_HI 2'h0

`endif

/* File: core/flash_block_address_decode.v */
// What this block does
// - Flash holds 64 sectors, each with 32 regular pages plus one spare page.
// - Each page has eight data blocks and one auxiliary block.
// - Data blocks carry sixteen bytes, the auxiliary block four bytes.
// - Address: sector 17:12, page 11:7, block 6:4, byte 3:0.
// - With spare page selected, page bits 11:7 are ignored.
// - With auxiliary block selected, bits 6:2 are ignored.
// - Writes to sector 0 spare page are refused with an error.
// - Reads of sector 0 spare page return all zero data.
//
// Purpose: Decode user requests into flash array coordinates
// Assumes: Inputs synchronous to ref_clk; one request per valid cycle
// Notes: All outputs registered; one cycle from request to decode
`timescale 1ns/100ps
`include "flash_addr_defs.vh"

module flash_block_address_decode #(
  parameter DATA_W = 8
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire req_valid,
  input wire req_write,
  input wire [`ADDR_W-1:0] addr,
  input wire spare_page_select,
  input wire aux_block_select,
  input wire [DATA_W-1:0] array_rdata,
  output reg [`SECTOR_W-1:0] sector_q,
  output reg [`PAGE_W-1:0] page_q,
  output reg [`BLOCK_W-1:0] block_q,
  output reg [`BYTE_W-1:0] byte_q,
  output reg spare_q,
  output reg aux_q,
  output reg array_req_q,
  output reg array_write_q,
  output reg error_q,
  output reg done_q,
  output reg [DATA_W-1:0] rdata_q
);

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  wire [`SECTOR_W-1:0] sector_d;
  wire [`PAGE_W-1:0] page_d;
  wire [`BLOCK_W-1:0] block_d;
  wire [`BYTE_W-1:0] byte_d;
  wire prot_hit;
  wire blocked_write;
  wire [DATA_W-1:0] rdata_d;
  reg zero_read_q;

  assign sector_d = addr[`SECTOR_HI:`SECTOR_LO];
  // Spare page has no page index, so the field is dropped
  assign page_d = spare_page_select ? `ZERO_PAGE : addr[`PAGE_HI:`PAGE_LO];
  // Auxiliary block overrides the data block index
  assign block_d = aux_block_select ? `ZERO_BLOCK : addr[`BLOCK_HI:`BLOCK_LO];
  // Four-byte auxiliary block uses only the low two byte bits
  assign byte_d = aux_block_select ?
    {`ZERO_AUX_HI, addr[`AUX_BYTE_HI:`AUX_BYTE_LO]} : addr[`BYTE_HI:`BYTE_LO];

  assign prot_hit = spare_page_select && (sector_d == `PROTECTED_SECTOR);
  assign blocked_write = req_valid && req_write && prot_hit;

  // ---------------------------------------------------------------
  // Decoded field registers
  // ---------------------------------------------------------------
  // Fields move only on an accepted request, so the array sees a
  // stable location between requests
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sector_q <= `PROTECTED_SECTOR;
    end
    else if (clk_en && req_valid)
    begin
      sector_q <= sector_d;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      page_q <= `ZERO_PAGE;
    end
    else if (clk_en && req_valid)
    begin
      page_q <= page_d;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      block_q <= `ZERO_BLOCK;
    end
    else if (clk_en && req_valid)
    begin
      block_q <= block_d;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      byte_q <= `ZERO_BYTE;
    end
    else if (clk_en && req_valid)
    begin
      byte_q <= byte_d;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      spare_q <= 1'b0;
    end
    else if (clk_en && req_valid)
    begin
      spare_q <= spare_page_select;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      aux_q <= 1'b0;
    end
    else if (clk_en && req_valid)
    begin
      aux_q <= aux_block_select;
    end
  end

  // ---------------------------------------------------------------
  // Handshake pulses
  // ---------------------------------------------------------------
  // Every accepted request is acknowledged, refused ones included
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      done_q <= req_valid;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      error_q <= 1'b0;
    end
    else if (clk_en)
    begin
      error_q <= blocked_write;
    end
  end

  // Protected page never reaches the array, so stored data cannot leak
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      array_req_q <= 1'b0;
    end
    else if (clk_en)
    begin
      array_req_q <= req_valid && !prot_hit;
    end
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      array_write_q <= 1'b0;
    end
    else if (clk_en)
    begin
      array_write_q <= req_valid && req_write && !prot_hit;
    end
  end

  // ---------------------------------------------------------------
  // Protected page read
  // ---------------------------------------------------------------
  // Marks the cycle whose array data must be replaced by zeroes
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      zero_read_q <= 1'b0;
    end
    else if (clk_en)
    begin
      zero_read_q <= req_valid && !req_write && prot_hit;
    end
  end

  // ---------------------------------------------------------------
  // Read data return
  // ---------------------------------------------------------------
  flash_zero_mux #(
    .DATA_W(DATA_W)
  ) u_zero (
    .din(array_rdata),
    .force_zero(zero_read_q),
    .dout(rdata_d)
  );

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_q <= {DATA_W{1'b0}};
    else if (clk_en)
      rdata_q <= rdata_d;
  end

endmodule // flash_block_address_decode

/* File: core/flash_zero_mux.v */
// Purpose: Per-bit forcing of read data to zero
// Assumes: Combinational, used inside the decode top
// Notes: One generate loop over the data bits
`timescale 1ns/100ps

module flash_zero_mux #(
  parameter DATA_W = 8
) (
  input wire [DATA_W-1:0] din,
  input wire force_zero,
  output wire [DATA_W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < DATA_W; i = i + 1)
    begin : g_bit
      assign dout[i] = din[i] & ~force_zero;
    end
  endgenerate

endmodule // flash_zero_mux

/* File: verification/flash_array_model.sv */
// Purpose: Flash array data source at the decode block's far side
// Assumes: One data byte per cycle
// Notes: Data changes every cycle, so a stale or unforced capture shows
`timescale 1ns/100ps
module flash_array_model (
  input wire ref_clk,
  output logic [7:0] array_rdata
);
  initial array_rdata = 8'h5A;
  always @(posedge ref_clk) array_rdata <= array_rdata + 8'h35;
endmodule // flash_array_model

/* File: verification/flash_decode_chk.sv */
// Purpose: Port checks of the flash address decode
// Assumes: clk_en stays high for two edges after a taken request
// Notes: Bound after the module
`timescale 1ns/100ps
module flash_decode_chk #(parameter DATA_W = 8) (
  input wire ref_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire req_valid,
  input wire req_write,
  input wire [17:0] addr,
  input wire spare_page_select,
  input wire aux_block_select,
  input wire [DATA_W-1:0] array_rdata,
  input wire [5:0] sector_q,
  input wire [4:0] page_q,
  input wire [2:0] block_q,
  input wire [3:0] byte_q,
  input wire spare_q,
  input wire aux_q,
  input wire array_req_q,
  input wire array_write_q,
  input wire error_q,
  input wire done_q,
  input wire [DATA_W-1:0] rdata_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire v = req_valid && clk_en;
  wire zr = done_q && !array_req_q && !error_q;
  wire s = spare_page_select;
  wire p = s && addr[17:12] == 6'h0;
  sequence s_zero_read;
    done_q && !array_req_q ##1 rdata_q == 0;
  endsequence
  a_sector_field: assert property (v |=> sector_q == $past(addr[17:12]))
    else $error("bad sector");
  a_spare_page: assert property (v && s |=> spare_q && page_q == 0)
    else $error("bad spare page");
  a_page_field: assert property (v && !s |=> page_q == $past(addr[11:7]))
    else $error("bad page");
  a_aux_block: assert property (v && aux_block_select |=> block_q == 0
    && byte_q == $past(addr[1:0])) else $error("bad aux block");
  a_data_block: assert property (v && !aux_block_select
    |=> {block_q, byte_q} == $past(addr[6:0])) else $error("bad block");
  a_write_refused: assert property (v && p && req_write
    |=> error_q && !array_req_q && !array_write_q) else $error("write not refused");
  a_read_zeroed: assert property (v && p && !req_write |=> s_zero_read)
    else $error("read not zero");
  a_request_passed: assert property (v && !p |=> done_q && array_req_q
    && array_write_q == $past(req_write) && !error_q) else $error("not passed");
  a_select_copies: assert property (v |=> spare_q == $past(s)
    && aux_q == $past(aux_block_select)) else $error("bad select copies");
  // Reset edge excluded: the register is cleared there, not loaded
  a_read_passed: assert property (clk_en && !sys_rst && !zr
    |=> rdata_q == $past(array_rdata)) else $error("read data not passed");
  a_frozen_hold: assert property (!clk_en |=> $stable({sector_q, page_q, block_q,
    byte_q, spare_q, aux_q, array_req_q, array_write_q, error_q, done_q, rdata_q}))
    else $error("state moved while frozen");
endmodule // flash_decode_chk
bind flash_block_address_decode flash_decode_chk #(.DATA_W(DATA_W)) i_chk (.*);

/* File: verification/tb.sv */
// Purpose: Random and corner requests against the flash decode
// Assumes: clk_en high except in the freeze corner case
// Notes: Two idle cycles between requests leave room for the zeroed read
`timescale 1ns/100ps
module tb;
  logic ref_clk = 0, sys_rst = 1, clk_en = 1, req_valid = 0, req_write = 0, sp = 0, ax = 0;
  logic [23:0] held;
  logic [7:0] held_r, want_r;
  logic [17:0] addr = 18'h0_0000;
  wire [7:0] ard, rdata;
  wire [23:0] got;
  int fails = 0, n_tests = 0;
  flash_array_model i_flash_array_model (.ref_clk(ref_clk), .array_rdata(ard));
  flash_block_address_decode i_flash_block_address_decode (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid), .req_write(req_write),
    .addr(addr), .spare_page_select(sp), .aux_block_select(ax), .array_rdata(ard),
    .sector_q(got[23:18]), .page_q(got[17:13]), .block_q(got[12:10]),
    .byte_q(got[9:6]), .spare_q(got[5]), .aux_q(got[4]), .array_req_q(got[3]),
    .array_write_q(got[2]), .error_q(got[1]), .done_q(got[0]), .rdata_q(rdata));
  initial forever #5 ref_clk = ~ref_clk;
  function [23:0] exp(input [17:0] a, input w, s, x);
    reg p;
    begin
      p = s && a[17:12] == 6'h0;
      exp = {a[17:12], s ? 5'h0 : a[11:7], x ? 3'h0 : a[6:4],
        x ? {2'h0, a[1:0]} : a[3:0], s, x, !p, !p && w, p && w, 1'b1};
    end
  endfunction
  // Read data: array byte one cycle late, zero for a read of the protected page
  function [7:0] rd_exp(input [7:0] d, input [17:0] a, input w, s);
    rd_exp = (s && a[17:12] == 6'h00 && !w) ? 8'h00 : d;
  endfunction
  task chk(input [23:0] seen, want);
    n_tests++;
    if (seen !== want)
    begin
      fails++;
      $display("wrong value %0t got %h want %h", $time, seen, want);
    end
  endtask
  task send(input [17:0] a, input w, s, x);
    @(posedge ref_clk);
    addr <= a;
    req_write <= w;
    sp <= s;
    ax <= x;
    req_valid <= 1;
    @(posedge ref_clk);
    req_valid <= 0;
    #1 chk(got, exp(a, w, s, x));
    want_r = ard;
    @(posedge ref_clk);
    #1 chk(rdata, rd_exp(want_r, a, w, s));
  endtask
  task end_of_test;
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    void'($urandom(74));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 0;
    #1 chk(got, 24'h00_0000);
    chk(rdata, 24'h00_0000);
    send(18'h0_0F85, 1, 1, 0);
    send(18'h0_0F87, 0, 1, 1);
    send(18'h3_FFFF, 1, 1, 1);
    // Frozen clock enable: a presented request must change nothing
    @(posedge ref_clk);
    clk_en <= 0;
    addr <= 18'h1_2345;
    req_write <= 1;
    sp <= 0;
    req_valid <= 1;
    #1 held = got;
    held_r = rdata;
    repeat (2) @(posedge ref_clk);
    #1 chk(got, held);
    chk(rdata, held_r);
    @(posedge ref_clk);
    clk_en <= 1;
    req_valid <= 0;
    repeat (150) send($urandom, $urandom, $urandom, $urandom);
    // Second reset in mid-run clears every output again
    @(posedge ref_clk);
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    #1 chk(got, 24'h00_0000);
    chk(rdata, 24'h00_0000);
    repeat (150) send($urandom, $urandom, $urandom, $urandom);
    end_of_test;
  end
endmodule // tb
